// File: src/irq_latch_defs.svh
// constants for the slicer/lock interrupt mask and range violation latch block
`ifndef IRQ_LATCH_DEFS_SVH
`define IRQ_LATCH_DEFS_SVH

// register sub-addresses
`define ADDR_LOCK_CHANGE_IRQ_MASK 8'h4c
`define ADDR_SLICER_EVENT_IRQ_STATUS 8'h4e
`define ADDR_SLICER_EVENT_IRQ_CLEAR 8'h4f
`define ADDR_SLICER_EVENT_IRQ_MASK 8'h50
`define ADDR_RANGE_VIOLATION_LATCH 8'h51

// lock change mask bits
`define BIT_OUT_STD_CHANGE 0
`define BIT_VLOCK_CHANGE 1
`define BIT_HLOCK_CHANGE 2
`define BIT_AUTODETECT_CHANGE 3
`define BIT_SEQ_COLOUR_LOCK_CHANGE 4
`define BIT_SWING_BURST_LOCK_CHANGE 5

// slicer event bits
`define BIT_CAPTION_DETECT 0
`define BIT_COPYPROT_WIDE_CHANGE 2

// range violation latch bits
`define BIT_RED_DIFF_OVER_MAX 0
`define BIT_RED_DIFF_UNDER_MIN 1
`define BIT_BLUE_DIFF_OVER_MAX 2
`define BIT_BLUE_DIFF_UNDER_MIN 3
`define BIT_LUMA_OVER_MAX 4
`define BIT_LUMA_UNDER_MIN 5

// implemented bits; all others read zero
`define LOCK_MASK_USED 8'h3f
`define SLICER_USED 8'h05
`define RANGE_USED 8'h3f

// reset values
`define MASK_RESET 8'h00
`define FLAGS_RESET 8'h00
`define BYTE_ZERO 8'h00

// serial port: device address is arbitrary
`define DEV_ADDR 7'h21
`define BITS_PER_BYTE 4'h8
`define BIT_COUNT_ZERO 4'h0

// copy-protection / widescreen payload width
`define COPYPROT_WIDE_WIDTH 14

`endif

// File: src/irq_latch_pkg.sv
// types shared by the interrupt mask and violation latch block
package irq_latch_pkg;

  typedef logic [7:0] reg8_t;

  // serial port states, gray steps along the write path
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ACK_ADDR = 4'h3,
    ST_SUB = 4'h2,
    ST_ACK_SUB = 4'h6,
    ST_WDATA = 4'h7,
    ST_ACK_W = 4'h5,
    ST_RDATA = 4'h4,
    ST_RACK = 4'hc
  } serial_state_t;

endpackage

// File: src/flag_bank_if.sv
// set, clear and state lines of one bank of sticky event flags
`timescale 1ns/1ps
`default_nettype none

interface flag_bank_if;
  irq_latch_pkg::reg8_t set;
  irq_latch_pkg::reg8_t clr;
  irq_latch_pkg::reg8_t flags;

  modport owner (input set, input clr, output flags);
  modport user (output set, output clr, input flags);
endinterface

`default_nettype wire

// File: src/sticky_flag_bank.sv
// eight sticky event flags, set wins over clear
`timescale 1ns/1ps
`default_nettype none
`include "irq_latch_defs.svh"

module sticky_flag_bank #(
  parameter irq_latch_pkg::reg8_t USED_BITS = `FLAGS_RESET
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  flag_bank_if.owner bank
);

  irq_latch_pkg::reg8_t flags_q;
  irq_latch_pkg::reg8_t flags_d;

  // an event in the clearing cycle survives
  always_comb begin
    flags_d = ((flags_q & ~bank.clr) | bank.set) & USED_BITS;
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      flags_q <= `FLAGS_RESET;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign bank.flags = flags_q;

endmodule // sticky_flag_bank

`default_nettype wire

// File: src/video_decoder_irq_mask_latch.sv
// interrupt masks, slicer event flags and range violation latch behind the serial port
//
// Operation
// [RULE_01] mask bit 0 gates output standard change
// [RULE_02] mask bit 1 gates vertical lock change
// [RULE_03] mask bit 2 gates horizontal lock change
// [RULE_04] mask bit 3 gates autodetect change
// [RULE_05] mask bit 4 gates sequential colour lock
// [RULE_06] mask bit 5 gates swinging burst lock
// [RULE_07] status bit 0 shows caption detected
// [RULE_08] status bit 2 shows copy-protect/widescreen change
// [RULE_09] config selects change-only or any detection
// [RULE_10] writing one to clear bit clears flag
// [RULE_11] slicer mask bits 0 and 2 gate flags
// [RULE_12] slicer flags come from VBI slicer only
// [RULE_13] latch bit 0: red-difference over max
// [RULE_14] latch bit 1: red-difference under min
// [RULE_15] latch bit 2: blue-difference over max
// [RULE_16] latch bit 3: blue-difference under min
// [RULE_17] latch bit 4: luma over max
// [RULE_18] latch bit 5: luma under min
// [RULE_19] latch holds until whole-latch clear control
// [RULE_20] output standard flips 60/50 Hz raise flag
// [RULE_21] irq while any unmasked flag set
`timescale 1ns/1ps
`default_nettype none
`include "irq_latch_defs.svh"

module video_decoder_irq_mask_latch (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe_n,
  input wire logic [5:0] i_lock_change_flags,
  input wire logic i_out_std_50hz,
  output logic o_out_std_change_pulse,
  input wire logic i_vbi_caption_valid,
  input wire logic i_vbi_copyprot_wide_valid,
  input wire logic [`COPYPROT_WIDE_WIDTH-1:0] i_vbi_copyprot_wide_data,
  input wire logic i_copyprot_wide_any_detect,
  input wire logic i_pix_valid,
  input wire logic [7:0] i_luma,
  input wire logic [7:0] i_blue_diff,
  input wire logic [7:0] i_red_diff,
  input wire logic [7:0] i_luma_max,
  input wire logic [7:0] i_luma_min,
  input wire logic [7:0] i_blue_diff_max,
  input wire logic [7:0] i_blue_diff_min,
  input wire logic [7:0] i_red_diff_max,
  input wire logic [7:0] i_red_diff_min,
  input wire logic i_range_violation_clear,
  output logic o_range_violation_any,
  output logic o_irq
);

  // returns {under_min, over_max}
  function automatic logic [1:0] range_check(input logic [7:0] value, input logic [7:0] lo,
                                             input logic [7:0] hi);
    range_check = {value < lo, value > hi};
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic scl_meta_q;
  logic scl_sync_q;
  logic scl_prev_q;
  logic sda_meta_q;
  logic sda_sync_q;
  logic sda_prev_q;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      scl_meta_q <= 1'b1;
      scl_sync_q <= 1'b1;
      scl_prev_q <= 1'b1;
      sda_meta_q <= 1'b1;
      sda_sync_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_meta_q <= i_scl;
      scl_sync_q <= scl_meta_q;
      scl_prev_q <= scl_sync_q;
      sda_meta_q <= i_sda;
      sda_sync_q <= sda_meta_q;
      sda_prev_q <= sda_sync_q;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  assign scl_rise = scl_sync_q & ~scl_prev_q;
  assign scl_fall = ~scl_sync_q & scl_prev_q;
  assign bus_start = scl_sync_q & scl_prev_q & sda_prev_q & ~sda_sync_q;
  assign bus_stop = scl_sync_q & scl_prev_q & ~sda_prev_q & sda_sync_q;

  //////////////////////////////////////////////////////////////////////////////
  // serial port engine

  irq_latch_pkg::serial_state_t state_q;
  irq_latch_pkg::reg8_t shift_q;
  irq_latch_pkg::reg8_t sub_q;
  irq_latch_pkg::reg8_t rd_data;
  logic [3:0] bit_cnt_q;
  logic drive_low_q;
  logic wr_en_q;
  irq_latch_pkg::reg8_t wr_data_q;
  irq_latch_pkg::reg8_t wr_addr_q;
  logic byte_done;

  assign byte_done = (bit_cnt_q == `BITS_PER_BYTE);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      bit_cnt_q <= `BIT_COUNT_ZERO;
      shift_q <= `BYTE_ZERO;
    end else if (bus_start) begin
      bit_cnt_q <= `BIT_COUNT_ZERO;
    end else if (scl_rise) begin
      bit_cnt_q <= bit_cnt_q + 4'h1;
      // acknowledge slots keep the received byte, so the read/write bit survives
      if (state_q == irq_latch_pkg::ST_ADDR || state_q == irq_latch_pkg::ST_SUB ||
          state_q == irq_latch_pkg::ST_WDATA) begin
        shift_q <= {shift_q[6:0], sda_sync_q};
      end
    end else if (scl_fall) begin
      if (byte_done || state_q == irq_latch_pkg::ST_ACK_W || state_q == irq_latch_pkg::ST_ACK_SUB ||
          state_q == irq_latch_pkg::ST_ACK_ADDR || state_q == irq_latch_pkg::ST_RACK) begin
        bit_cnt_q <= `BIT_COUNT_ZERO;
      end
      if (state_q == irq_latch_pkg::ST_RACK ||
          (state_q == irq_latch_pkg::ST_ACK_ADDR && shift_q[0])) begin
        shift_q <= rd_data;
      end
    end
  end

  logic read_nack_q;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_q <= irq_latch_pkg::ST_IDLE;
      drive_low_q <= 1'b0;
      sub_q <= `BYTE_ZERO;
      read_nack_q <= 1'b0;
    end else if (bus_start) begin
      state_q <= irq_latch_pkg::ST_ADDR;
      drive_low_q <= 1'b0;
    end else if (bus_stop) begin
      state_q <= irq_latch_pkg::ST_IDLE;
      drive_low_q <= 1'b0;
    end else if (scl_rise && state_q == irq_latch_pkg::ST_RACK) begin
      read_nack_q <= sda_sync_q;
    end else if (scl_fall) begin
      case (state_q)
        irq_latch_pkg::ST_ADDR: begin
          if (byte_done) begin
            if (shift_q[7:1] == `DEV_ADDR) begin
              state_q <= irq_latch_pkg::ST_ACK_ADDR;
              drive_low_q <= 1'b1;
            end else begin
              state_q <= irq_latch_pkg::ST_IDLE;
            end
          end
        end
        irq_latch_pkg::ST_ACK_ADDR: begin
          if (shift_q[0]) begin
            state_q <= irq_latch_pkg::ST_RDATA;
            drive_low_q <= ~rd_data[7];
            sub_q <= sub_q + 8'h01;
          end else begin
            state_q <= irq_latch_pkg::ST_SUB;
            drive_low_q <= 1'b0;
          end
        end
        irq_latch_pkg::ST_SUB: begin
          if (byte_done) begin
            state_q <= irq_latch_pkg::ST_ACK_SUB;
            sub_q <= shift_q;
            drive_low_q <= 1'b1;
          end
        end
        irq_latch_pkg::ST_ACK_SUB: begin
          state_q <= irq_latch_pkg::ST_WDATA;
          drive_low_q <= 1'b0;
        end
        irq_latch_pkg::ST_WDATA: begin
          if (byte_done) begin
            state_q <= irq_latch_pkg::ST_ACK_W;
            drive_low_q <= 1'b1;
          end
        end
        irq_latch_pkg::ST_ACK_W: begin
          state_q <= irq_latch_pkg::ST_WDATA;
          sub_q <= sub_q + 8'h01;
          drive_low_q <= 1'b0;
        end
        irq_latch_pkg::ST_RDATA: begin
          if (byte_done) begin
            state_q <= irq_latch_pkg::ST_RACK;
            drive_low_q <= 1'b0;
          end else begin
            drive_low_q <= ~shift_q[3'(4'h7 - bit_cnt_q)];
          end
        end
        irq_latch_pkg::ST_RACK: begin
          if (read_nack_q) begin
            state_q <= irq_latch_pkg::ST_IDLE;
            drive_low_q <= 1'b0;
          end else begin
            state_q <= irq_latch_pkg::ST_RDATA;
            drive_low_q <= ~rd_data[7];
            sub_q <= sub_q + 8'h01;
          end
        end
        default: begin
          drive_low_q <= 1'b0;
        end
      endcase
    end
  end

  // one-cycle register write strobe at the end of each data byte
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wr_en_q <= 1'b0;
      wr_addr_q <= `BYTE_ZERO;
      wr_data_q <= `BYTE_ZERO;
    end else begin
      wr_en_q <= scl_fall && byte_done && state_q == irq_latch_pkg::ST_WDATA && !bus_start && !bus_stop;
      wr_addr_q <= sub_q;
      wr_data_q <= shift_q;
    end
  end

  // open drain: only ever pulls low
  assign o_sda = 1'b0;
  assign o_sda_oe_n = ~drive_low_q;

  //////////////////////////////////////////////////////////////////////////////
  // mask registers

  irq_latch_pkg::reg8_t lock_change_irq_mask_q;
  irq_latch_pkg::reg8_t slicer_event_irq_mask_q;
  logic slicer_clear_wr;

  assign slicer_clear_wr = wr_en_q && wr_addr_q == `ADDR_SLICER_EVENT_IRQ_CLEAR;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      lock_change_irq_mask_q <= `MASK_RESET;
    end else if (wr_en_q && wr_addr_q == `ADDR_LOCK_CHANGE_IRQ_MASK) begin
      lock_change_irq_mask_q <= wr_data_q & `LOCK_MASK_USED;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      slicer_event_irq_mask_q <= `MASK_RESET;
    end else if (wr_en_q && wr_addr_q == `ADDR_SLICER_EVENT_IRQ_MASK) begin
      // [RULE_11] slicer mask write
      slicer_event_irq_mask_q <= wr_data_q & `SLICER_USED;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // output standard change detect

  logic std_50hz_prev_q;

  // tracking the pin through reset avoids a false pulse and a missed first flip
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      std_50hz_prev_q <= i_out_std_50hz;
      o_out_std_change_pulse <= 1'b0;
    end else begin
      std_50hz_prev_q <= i_out_std_50hz;
      // [RULE_20] 60/50 Hz flip
      o_out_std_change_pulse <= (std_50hz_prev_q != i_out_std_50hz);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // slicer events

  flag_bank_if slicer_bank ();
  logic [`COPYPROT_WIDE_WIDTH-1:0] copyprot_last_q;
  logic copyprot_seen_q;
  logic copyprot_event;

  // [RULE_09] change-only or any detection
  assign copyprot_event = i_vbi_copyprot_wide_valid && (i_copyprot_wide_any_detect || !copyprot_seen_q ||
                          i_vbi_copyprot_wide_data != copyprot_last_q);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      copyprot_last_q <= '0;
      copyprot_seen_q <= 1'b0;
    end else if (i_vbi_copyprot_wide_valid) begin
      copyprot_last_q <= i_vbi_copyprot_wide_data;
      copyprot_seen_q <= 1'b1;
    end
  end

  always_comb begin
    slicer_bank.set = `FLAGS_RESET;
    // [RULE_12] sourced from VBI slicer
    slicer_bank.set[`BIT_CAPTION_DETECT] = i_vbi_caption_valid;
    slicer_bank.set[`BIT_COPYPROT_WIDE_CHANGE] = copyprot_event;
    // [RULE_10] write one clears
    slicer_bank.clr = slicer_clear_wr ? wr_data_q & `SLICER_USED : `FLAGS_RESET;
  end

  // [RULE_07] [RULE_08] sticky slicer status
  sticky_flag_bank #(
    .USED_BITS(`SLICER_USED)
  ) u_slicer_flags (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .bank(slicer_bank.owner)
  );

  //////////////////////////////////////////////////////////////////////////////
  // range violation latch

  flag_bank_if range_bank ();
  logic [1:0] luma_chk;
  logic [1:0] blue_chk;
  logic [1:0] red_chk;

  assign luma_chk = range_check(i_luma, i_luma_min, i_luma_max);
  assign blue_chk = range_check(i_blue_diff, i_blue_diff_min, i_blue_diff_max);
  assign red_chk = range_check(i_red_diff, i_red_diff_min, i_red_diff_max);

  always_comb begin
    range_bank.set = `FLAGS_RESET;
    // [RULE_13] red over max
    range_bank.set[`BIT_RED_DIFF_OVER_MAX] = i_pix_valid & red_chk[0];
    // [RULE_14] red under min
    range_bank.set[`BIT_RED_DIFF_UNDER_MIN] = i_pix_valid & red_chk[1];
    // [RULE_15] blue over max
    range_bank.set[`BIT_BLUE_DIFF_OVER_MAX] = i_pix_valid & blue_chk[0];
    // [RULE_16] blue under min
    range_bank.set[`BIT_BLUE_DIFF_UNDER_MIN] = i_pix_valid & blue_chk[1];
    // [RULE_17] luma over max
    range_bank.set[`BIT_LUMA_OVER_MAX] = i_pix_valid & luma_chk[0];
    // [RULE_18] luma under min
    range_bank.set[`BIT_LUMA_UNDER_MIN] = i_pix_valid & luma_chk[1];
    // [RULE_19] whole latch clear
    range_bank.clr = i_range_violation_clear ? `RANGE_USED : `FLAGS_RESET;
  end

  sticky_flag_bank #(
    .USED_BITS(`RANGE_USED)
  ) u_range_latch (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .bank(range_bank.owner)
  );

  assign o_range_violation_any = |range_bank.flags;

  //////////////////////////////////////////////////////////////////////////////
  // read mux and interrupt

  always_comb begin
    case (sub_q)
      `ADDR_LOCK_CHANGE_IRQ_MASK: rd_data = lock_change_irq_mask_q;
      `ADDR_SLICER_EVENT_IRQ_STATUS: rd_data = slicer_bank.flags;
      `ADDR_SLICER_EVENT_IRQ_MASK: rd_data = slicer_event_irq_mask_q;
      `ADDR_RANGE_VIOLATION_LATCH: rd_data = range_bank.flags;
      default: rd_data = `BYTE_ZERO;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_irq <= 1'b0;
    end else begin
      // [RULE_01] [RULE_02] [RULE_03] [RULE_04] [RULE_05] [RULE_06] lock masks
      // [RULE_21] any unmasked flag
      o_irq <= |({2'b00, i_lock_change_flags} & lock_change_irq_mask_q) ||
               |(slicer_bank.flags & slicer_event_irq_mask_q);
    end
  end

endmodule // video_decoder_irq_mask_latch

`default_nettype wire

// File: tb/irq_mask_latch_chk.sv
// port assertions for the interrupt mask and violation latch block
`timescale 1ns/1ps
`default_nettype none

module irq_mask_latch_chk (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_out_std_50hz,
  input wire logic o_out_std_change_pulse,
  input wire logic i_pix_valid,
  input wire logic [7:0] i_luma,
  input wire logic [7:0] i_blue_diff,
  input wire logic [7:0] i_red_diff,
  input wire logic [7:0] i_luma_max,
  input wire logic [7:0] i_luma_min,
  input wire logic [7:0] i_blue_diff_max,
  input wire logic [7:0] i_blue_diff_min,
  input wire logic [7:0] i_red_diff_max,
  input wire logic [7:0] i_red_diff_min,
  input wire logic i_range_violation_clear,
  input wire logic o_range_violation_any,
  input wire logic o_sda_oe_n,
  input wire logic o_irq
);
  logic viol;

  // any channel outside its limits this cycle
  assign viol = i_pix_valid && (i_red_diff > i_red_diff_max || i_red_diff < i_red_diff_min
    || i_blue_diff > i_blue_diff_max || i_blue_diff < i_blue_diff_min
    || i_luma > i_luma_max || i_luma < i_luma_min);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  ////////////////////////////////////////
  a_reset_quiet: assert property (disable iff (1'b0)
    i_sys_rst |=> !o_irq && o_sda_oe_n && !o_out_std_change_pulse && !o_range_violation_any)
    else $error("outputs active during reset");
  a_std_flip_pulse: assert property ($changed(i_out_std_50hz) |=> o_out_std_change_pulse)
    else $error("no pulse after standard flip");
  a_std_pulse_cause: assert property (
    o_out_std_change_pulse |-> $past(i_out_std_50hz) != $past(i_out_std_50hz, 2))
    else $error("pulse without standard flip");
  a_std_pulse_single: assert property (
    o_out_std_change_pulse && $stable(i_out_std_50hz) |=> !o_out_std_change_pulse)
    else $error("standard pulse too long");
  a_range_set: assert property (viol |-> ##[1:2] o_range_violation_any)
    else $error("violation not latched");
  a_range_cause: assert property ($rose(o_range_violation_any) |-> $past(viol) || $past(viol, 2))
    else $error("latch set without violation");
  a_range_hold: assert property (
    o_range_violation_any && !i_range_violation_clear && !$past(i_range_violation_clear)
    |=> o_range_violation_any)
    else $error("latch lost without clear");
  a_range_clear: assert property (
    i_range_violation_clear && !viol && !$past(viol) |-> ##[1:2] !o_range_violation_any)
    else $error("latch not cleared");
endmodule // irq_mask_latch_chk

bind video_decoder_irq_mask_latch irq_mask_latch_chk chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_out_std_50hz(i_out_std_50hz), .o_out_std_change_pulse(o_out_std_change_pulse),
  .i_pix_valid(i_pix_valid), .i_luma(i_luma), .i_blue_diff(i_blue_diff), .i_red_diff(i_red_diff),
  .i_luma_max(i_luma_max), .i_luma_min(i_luma_min), .i_blue_diff_max(i_blue_diff_max),
  .i_blue_diff_min(i_blue_diff_min), .i_red_diff_max(i_red_diff_max), .i_red_diff_min(i_red_diff_min),
  .i_range_violation_clear(i_range_violation_clear), .o_range_violation_any(o_range_violation_any),
  .o_sda_oe_n(o_sda_oe_n), .o_irq(o_irq));

`default_nettype wire

// File: tb/serial_host_model.sv
// two-wire host that reads and writes the block's registers
`timescale 1ns/1ps
`default_nettype none
`include "irq_latch_defs.svh"

module serial_host_model (
  input wire logic i_clk,
  input wire logic i_dev_oe_n,
  output logic o_scl,
  output var logic o_sda
);
  logic pull_low = 1'b0;

  // open-drain data line with pull-up
  assign o_sda = !(pull_low || !i_dev_oe_n);
  initial o_scl = 1'b1;

  ////////////////////////////////////////
  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic start();
    pull_low = 1'b0;
    wait_clk(8);
    o_scl = 1'b1;
    wait_clk(8);
    pull_low = 1'b1;
    wait_clk(8);
    o_scl = 1'b0;
    wait_clk(2);
  endtask

  task automatic stop();
    pull_low = 1'b1;
    wait_clk(8);
    o_scl = 1'b1;
    wait_clk(8);
    pull_low = 1'b0;
    wait_clk(8);
  endtask

  // eight bits msb first, then the acknowledge slot with data released
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack_n);
    logic [8:0] got;
    for (int i = 8; i >= 0; i--) begin
      pull_low = (i > 0) ? !tx[i-1] : 1'b0;
      wait_clk(8);
      o_scl = 1'b1;
      wait_clk(4);
      got[i] = o_sda;
      wait_clk(4);
      o_scl = 1'b0;
      wait_clk(2);
    end
    rx = got[8:1];
    ack_n = got[0];
  endtask

  task automatic write_reg(input logic [7:0] sub, input logic [7:0] data, output logic ok);
    logic [7:0] rx;
    logic [2:0] nak;
    start();
    xfer({`DEV_ADDR, 1'b0}, rx, nak[0]);
    xfer(sub, rx, nak[1]);
    xfer(data, rx, nak[2]);
    stop();
    ok = (nak === 3'b000);
  endtask

  task automatic read_reg(input logic [7:0] sub, output logic [7:0] data, output logic ok);
    logic [7:0] rx;
    logic [2:0] nak;
    logic host_nak;
    start();
    xfer({`DEV_ADDR, 1'b0}, rx, nak[0]);
    xfer(sub, rx, nak[1]);
    start();
    xfer({`DEV_ADDR, 1'b1}, rx, nak[2]);
    xfer(8'hff, data, host_nak);
    stop();
    ok = (nak === 3'b000);
  endtask
endmodule // serial_host_model

`default_nettype wire

// File: tb/video_decoder_irq_mask_latch_bench.sv
// self-checking bench for the interrupt mask and violation latch block
`timescale 1ns/1ps
`default_nettype none
`include "irq_latch_defs.svh"

module video_decoder_irq_mask_latch_bench;
  logic i_clk, i_sys_rst, scl, sda, pix, clr, std50, cap_v, cw_v, any_det;
  logic o_sda, oe_n, pulse, viol_any, irq, ok;
  logic [5:0] lock;
  logic [`COPYPROT_WIDE_WIDTH-1:0] cw_data;
  logic [7:0] luma, blue, red, lim_max, lim_min, rd;
  logic [7:0] addrs [6] = '{8'h4c, 8'h4d, 8'h4e, 8'h4f, 8'h50, 8'h51};
  int n_errors = 0;
  int checks = 0;

  video_decoder_irq_mask_latch DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_scl(scl), .i_sda(sda),
    .o_sda(o_sda), .o_sda_oe_n(oe_n), .i_lock_change_flags(lock), .i_out_std_50hz(std50),
    .o_out_std_change_pulse(pulse), .i_vbi_caption_valid(cap_v), .i_vbi_copyprot_wide_valid(cw_v),
    .i_vbi_copyprot_wide_data(cw_data), .i_copyprot_wide_any_detect(any_det), .i_pix_valid(pix),
    .i_luma(luma), .i_blue_diff(blue), .i_red_diff(red), .i_luma_max(lim_max), .i_luma_min(lim_min),
    .i_blue_diff_max(lim_max), .i_blue_diff_min(lim_min), .i_red_diff_max(lim_max),
    .i_red_diff_min(lim_min), .i_range_violation_clear(clr), .o_range_violation_any(viol_any),
    .o_irq(irq));

  serial_host_model host (.i_clk(i_clk), .i_dev_oe_n(oe_n), .o_scl(scl), .o_sda(sda));

  ////////////////////////////////////////
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.write_reg(a, d, ok);
    chk("write ack", 8'h01, {7'h0, ok});
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    host.read_reg(a, rd, ok);
    chk("read ack", 8'h01, {7'h0, ok});
    chk("read data", exp, rd);
  endtask

  task automatic pulse_cw();
    cw_v = 1'b1;
    tick(1);
    cw_v = 1'b0;
    tick(3);
  endtask

  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // about 40 register accesses of roughly 540 to 720 cycles each
  initial begin
    #1_000_000;
    n_errors++;
    complete_run();
  end

  initial begin
    {i_sys_rst, pix, clr, std50, cap_v, cw_v, any_det} = 7'b1000000;
    lock = 6'h00;
    cw_data = 14'h01a5;
    {lim_max, lim_min} = {8'hc0, 8'h40};
    {luma, blue, red} = {8'h40, 8'hc0, 8'h40};
    tick(3);
    i_sys_rst = 1'b0;
    chk("irq after reset", 8'h00, {7'h0, irq});
    chk("sda enable", 8'h01, {7'h0, oe_n});
    chk("sda value", 8'h00, {7'h0, o_sda});
    tick(5);
    foreach (addrs[i]) rdchk(addrs[i], 8'h00);
    wr(8'h4c, 8'hff);
    rdchk(8'h4c, 8'h3f);
    wr(8'h50, 8'hff);
    rdchk(8'h50, 8'h05);
    wr(8'h51, 8'hff);
    rdchk(8'h51, 8'h00);
    wr(8'h50, 8'h00);
    for (int b = 0; b < 6; b++) begin
      wr(8'h4c, 8'h01 << b);
      lock = ~(6'h01 << b);
      tick(3);
      chk("irq masked", 8'h00, {7'h0, irq});
      lock = 6'h01 << b;
      tick(3);
      chk("irq unmasked", 8'h01, {7'h0, irq});
    end
    lock = 6'h00;
    cap_v = 1'b1;
    tick(1);
    cap_v = 1'b0;
    tick(3);
    rdchk(8'h4e, 8'h01);
    chk("irq slicer masked", 8'h00, {7'h0, irq});
    wr(8'h50, 8'h01);
    tick(3);
    chk("irq caption", 8'h01, {7'h0, irq});
    pulse_cw();
    rdchk(8'h4e, 8'h05);
    wr(8'h4f, 8'h01);
    rdchk(8'h4e, 8'h04);
    chk("irq after clear", 8'h00, {7'h0, irq});
    wr(8'h4f, 8'h00);
    rdchk(8'h4e, 8'h04);
    wr(8'h4f, 8'h04);
    rdchk(8'h4e, 8'h00);
    pulse_cw();
    rdchk(8'h4e, 8'h00);
    any_det = 1'b1;
    pulse_cw();
    rdchk(8'h4e, 8'h04);
    wr(8'h50, 8'h04);
    tick(3);
    chk("irq copyprot", 8'h01, {7'h0, irq});
    wr(8'h4f, 8'h04);
    tick(3);
    chk("irq cleared", 8'h00, {7'h0, irq});
    any_det = 1'b0;
    cw_data = 14'h02b6;
    pulse_cw();
    rdchk(8'h4e, 8'h04);
    for (int b = 0; b < 7; b++) begin
      red = (b == 0) ? 8'hc1 : (b == 1) ? 8'h3f : 8'h40;
      blue = (b == 2) ? 8'hc1 : (b == 3) ? 8'h3f : 8'hc0;
      luma = (b == 4) ? 8'hc1 : (b == 5) ? 8'h3f : 8'h40;
      pix = 1'b1;
      tick(1);
      pix = 1'b0;
      tick(3);
      rdchk(8'h51, (b < 6) ? (8'h01 << b) : 8'h00);
      chk("latch any", (b < 6) ? 8'h01 : 8'h00, {7'h0, viol_any});
      clr = 1'b1;
      tick(1);
      clr = 1'b0;
      tick(3);
      chk("latch cleared", 8'h00, {7'h0, viol_any});
    end
    for (int k = 0; k < 2; k++) begin
      std50 = ~std50;
      tick(1);
      chk("std pulse", 8'h01, {7'h0, pulse});
      tick(1);
      chk("std pulse end", 8'h00, {7'h0, pulse});
    end
    complete_run();
  end
endmodule // video_decoder_irq_mask_latch_bench

`default_nettype wire
